/* File: rscd_strap_decoder.sv */
// strap capture, decode and apb register file
//
// How it works
// RULE1: all straps captured during reset and used for configuration; the code captures them on the first pclk edge after presetn rises
// RULE2: bypass bit 0 low gives system clock times five, high direct
// RULE3: clock select 1, bypass 1 low doubles memory clock, high direct
// RULE4: bypass bit 2 low gives spacewire times eight, high direct, pll off
// RULE5: clock select open takes memory clock from external input
// RULE6: break inactive lets first processor run, active keeps it halted
// RULE7: debug unit strap enables debug unit and its links; the code drives only debug_support_unit_en from it
// RULE8: watchdog strap couples watchdog timeout to board reset
// RULE9: memory width strap selects primary sdram width
// RULE10: half width gives upper pins to pci when high, ethernet when low
// RULE11: straps 0 to 5 set debug link address, all ones disable it
// RULE12: straps 6 and 7 set router interrupt configuration
// RULE13: straps 8 and 9 route debug link traffic, both high to debug bus
// RULE14: strap 10 low gives 8-bit prom, high gives 16-bit
// RULE15: straps 12 and 13 give router instance id
// RULE16: strap 14 low disables prom error correction, high enables
// RULE17: strap 15 low selects prom io pins, high alternative functions
// RULE18: strap 15 sets only reset state, software may change later
// RULE19: strap 15 low loads pin function bits all one, high all zero
// RULE20: captured values hold until next reset except software override
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module rscd_strap_decoder
  import rscd_pkg::*;
(
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // strap pins
  input  wire rscd_strap_type strap_in,
  // apb slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // decoded configuration
  output rscd_clk_type        clk_cfg,
  output logic                cpu0_run,
  output logic                debug_support_unit_en,
  output logic                watchdog_reset_enable,
  output logic                memory_width_full,
  output logic                upper_pins_pci,
  output logic                upper_pins_eth1,
  output logic [5:0]          ethernet_debug_link_addr,
  output logic                ethernet_debug_link_en,
  output logic [1:0]          router_irq_cfg,
  output logic [1:0]          ethernet_debug_link_route,
  output logic                ethernet_debug_link_to_dbg,
  output logic                prom_width16,
  output logic [1:0]          router_instance_id,
  output logic                prom_edac_en,
  output logic [21:0]         pin_function_enable_register,
  output logic                config_valid
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  rscd_state_type state_r;
  rscd_strap_type strap_r;
  logic [21:0]    pinfn_r;
  logic [21:0]    pinfn_nxt;
  logic [31:0]    rdata_nxt;

  // ------------------------------------------------------------------
  // decode of captured straps
  // ------------------------------------------------------------------
  function automatic logic all_ones6(input logic [5:0] v);
    all_ones6 = (v == RSCD_ETHERNET_DEBUG_LINK_OFF);
  endfunction : all_ones6

  rscd_clk_type clk_dec;
  wire logic    sys_byp    = strap_r.pll_bypass[0];
  wire logic    mem_byp    = strap_r.pll_bypass[1];
  wire logic    spw_byp    = strap_r.pll_bypass[2];
  wire logic    mem_ext    = strap_r.mem_clksel;
  wire logic    ethernet_debug_link_off   = all_ones6(strap_r.gpio[5:0]);
  wire logic    route_dbg  = (strap_r.gpio[9:8] == RSCD_ROUTE_DBG);
  wire logic    half_width = ~strap_r.mem_width;

  always_comb begin
    clk_dec.sys_mul     = sys_byp ? RSCD_MUL_ONE : RSCD_MUL_SYS;          // see RULE2
    clk_dec.sys_pll_en  = ~sys_byp;                                       // see RULE2
    clk_dec.mem_ext_src = mem_ext;                                        // see RULE5
    // shared-source case multiplies by one
    clk_dec.mem_mul     = (mem_ext && !mem_byp) ? RSCD_MUL_MEM : RSCD_MUL_ONE; // see RULE3
    clk_dec.mem_pll_en  = mem_ext & ~mem_byp;                             // see RULE3
    clk_dec.spw_mul     = spw_byp ? RSCD_MUL_ONE : RSCD_MUL_SPW;          // see RULE4
    clk_dec.spw_pll_en  = ~spw_byp;                                       // see RULE4
  end

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  wire logic acc      = psel & penable;
  wire logic hit_pin  = (paddr == RSCD_OFS_PINFN);
  wire logic mapped   = (paddr == RSCD_OFS_STRAP) | (paddr == RSCD_OFS_CLOCK) |
                        (paddr == RSCD_OFS_SYSCFG) | (paddr == RSCD_OFS_ROUTE) | hit_pin;
  wire logic wr_pinfn = acc & pwrite & hit_pin & (state_r == RSCD_ST_RUN);

  assign pinfn_nxt = wr_pinfn ? pwdata[21:0] : pinfn_r;                   // see RULE18

  always_comb begin
    rdata_nxt = 32'h00000000;
    case (paddr)
      RSCD_OFS_STRAP:  rdata_nxt = {6'h00, strap_r};
      RSCD_OFS_CLOCK:  rdata_nxt = {16'h0000, clk_dec};
      RSCD_OFS_SYSCFG: rdata_nxt = {26'h0000000, strap_r.break_n, strap_r.dsu_en,
                                    strap_r.wdog_en, strap_r.mem_width,
                                    strap_r.pci_mode, strap_r.pll_lock_ignore};
      RSCD_OFS_ROUTE:  rdata_nxt = {16'h0000, strap_r.gpio};
      RSCD_OFS_PINFN:  rdata_nxt = {10'h000, pinfn_r};
      default:         rdata_nxt = 32'h00000000;
    endcase
  end

  // ------------------------------------------------------------------
  // capture and hold
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= RSCD_ST_CAPTURE;
      strap_r <= '0;
    end else if (state_r == RSCD_ST_CAPTURE) begin
      state_r <= RSCD_ST_RUN;
      strap_r <= strap_in;                                                // see RULE1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pinfn_r <= RSCD_PINFN_PROM;
    end else if (state_r == RSCD_ST_CAPTURE) begin
      pinfn_r <= strap_in.gpio[RSCD_GP_PINMUX] ? RSCD_PINFN_PERI : RSCD_PINFN_PROM; // see RULE19
    end else begin
      pinfn_r <= pinfn_nxt;                                               // see RULE20
    end
  end

  // ------------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rdata_nxt : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cfg                      <= '0;
      cpu0_run                     <= 1'b0;
      debug_support_unit_en        <= 1'b0;
      watchdog_reset_enable        <= 1'b0;
      memory_width_full            <= 1'b0;
      upper_pins_pci               <= 1'b0;
      upper_pins_eth1              <= 1'b0;
      ethernet_debug_link_addr     <= 6'h00;
      ethernet_debug_link_en       <= 1'b0;
      router_irq_cfg               <= 2'h0;
      ethernet_debug_link_route    <= 2'h0;
      ethernet_debug_link_to_dbg   <= 1'b0;
      prom_width16                 <= 1'b0;
      router_instance_id           <= 2'h0;
      prom_edac_en                 <= 1'b0;
      pin_function_enable_register <= RSCD_PINFN_PROM;
      config_valid                 <= 1'b0;
    end else begin
      clk_cfg                      <= clk_dec;                            // see RULE1
      cpu0_run                     <= strap_r.break_n;                    // see RULE6
      debug_support_unit_en        <= strap_r.dsu_en;                     // see RULE7
      watchdog_reset_enable        <= strap_r.wdog_en;                    // see RULE8
      memory_width_full            <= strap_r.mem_width;                  // see RULE9
      upper_pins_pci               <= half_width & strap_r.pci_mode;      // see RULE10
      upper_pins_eth1              <= half_width & ~strap_r.pci_mode;     // see RULE10
      ethernet_debug_link_addr     <= strap_r.gpio[5:0];                  // see RULE11
      ethernet_debug_link_en       <= ~ethernet_debug_link_off;                          // see RULE11
      router_irq_cfg               <= strap_r.gpio[7:6];                  // see RULE12
      ethernet_debug_link_route    <= strap_r.gpio[9:8];                  // see RULE13
      ethernet_debug_link_to_dbg   <= route_dbg;                          // see RULE13
      prom_width16                 <= strap_r.gpio[RSCD_GP_PROMW];        // see RULE14
      router_instance_id           <= strap_r.gpio[13:12];                // see RULE15
      prom_edac_en                 <= strap_r.gpio[RSCD_GP_PEDAC];        // see RULE16
      pin_function_enable_register <= pinfn_r;                            // see RULE17
      config_valid                 <= (state_r == RSCD_ST_RUN);
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence s_settled;
    config_valid ##1 config_valid;
  endsequence

  property p_sys_clock;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (clk_cfg.sys_mul == (strap_r.pll_bypass[0] ? 4'h1 : 4'h5));
  endproperty
  a_sys_clock: assert property (p_sys_clock) else $error("system multiplier wrong"); // see RULE2

  property p_mem_clock;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (clk_cfg.mem_mul ==
        ((strap_r.mem_clksel && !strap_r.pll_bypass[1]) ? 4'h2 : 4'h1));
  endproperty
  a_mem_clock: assert property (p_mem_clock) else $error("memory multiplier wrong"); // see RULE3

  property p_spw_clock;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (clk_cfg.spw_pll_en == !strap_r.pll_bypass[2]) &&
                    (clk_cfg.spw_mul == (strap_r.pll_bypass[2] ? 4'h1 : 4'h8));
  endproperty
  a_spw_clock: assert property (p_spw_clock) else $error("spacewire clock wrong"); // see RULE4

  property p_ethernet_debug_link_off;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (ethernet_debug_link_en == (strap_r.gpio[5:0] != 6'h3F));
  endproperty
  a_ethernet_debug_link_off: assert property (p_ethernet_debug_link_off) else $error("debug link enable wrong"); // see RULE11

  property p_upper_pins;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (upper_pins_pci == (!memory_width_full && strap_r.pci_mode)) &&
                    (upper_pins_eth1 == (!memory_width_full && !strap_r.pci_mode));
  endproperty
  a_upper_pins: assert property (p_upper_pins) else $error("upper pin sharing wrong"); // see RULE10

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (state_r == RSCD_ST_RUN) ##1 (state_r == RSCD_ST_RUN) |-> $stable(strap_r);
  endproperty
  a_hold: assert property (p_hold) else $error("captured straps changed"); // see RULE20

  property p_pinfn_load;
    @(posedge pclk) disable iff (!presetn)
      (state_r == RSCD_ST_CAPTURE) |=> (pinfn_r == (strap_r.gpio[15] ? 22'h000000 : 22'h3FFFFF));
  endproperty
  a_pinfn_load: assert property (p_pinfn_load) else $error("pin function reset wrong"); // see RULE19

  property p_pinfn_write;
    @(posedge pclk) disable iff (!presetn)
      wr_pinfn |=> (pinfn_r == $past(pwdata[21:0])) ##1
                   (pin_function_enable_register == $past(pwdata[21:0], 2));
  endproperty
  a_pinfn_write: assert property (p_pinfn_write) else $error("pin function write lost"); // see RULE18

  property p_prom;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (prom_width16 == strap_r.gpio[10]) && (prom_edac_en == strap_r.gpio[14]);
  endproperty
  a_prom: assert property (p_prom) else $error("prom settings wrong"); // see RULE14

  sequence s_capture;
    (state_r == RSCD_ST_CAPTURE) ##1 (state_r == RSCD_ST_RUN);
  endsequence

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
      s_capture |-> (strap_r == $past(strap_in));
  endproperty
  a_capture: assert property (p_capture) else $error("straps not captured"); // see RULE1

  property p_valid_time;
    @(posedge pclk) disable iff (!presetn)
      s_capture |=> config_valid;
  endproperty
  a_valid_time: assert property (p_valid_time) else $error("config valid late"); // see RULE1

  property p_sys_pll;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (clk_cfg.sys_pll_en == !strap_r.pll_bypass[0]);
  endproperty
  a_sys_pll: assert property (p_sys_pll) else $error("system pll enable wrong"); // see RULE2

  property p_mem_src;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (clk_cfg.mem_ext_src == strap_r.mem_clksel) &&
                    (strap_r.mem_clksel || !clk_cfg.mem_pll_en);
  endproperty
  a_mem_src: assert property (p_mem_src) else $error("memory clock source wrong"); // see RULE5

  property p_run;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (cpu0_run == strap_r.break_n);
  endproperty
  a_run: assert property (p_run) else $error("processor start wrong"); // see RULE6

  property p_dsu;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (debug_support_unit_en == strap_r.dsu_en);
  endproperty
  a_dsu: assert property (p_dsu) else $error("debug unit enable wrong"); // see RULE7

  property p_wdog;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (watchdog_reset_enable == strap_r.wdog_en);
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog coupling wrong"); // see RULE8

  property p_width;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (memory_width_full == strap_r.mem_width);
  endproperty
  a_width: assert property (p_width) else $error("memory width wrong"); // see RULE9

  property p_ethernet_debug_link_addr;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (ethernet_debug_link_addr == strap_r.gpio[5:0]);
  endproperty
  a_ethernet_debug_link_addr: assert property (p_ethernet_debug_link_addr) else $error("debug link address wrong"); // see RULE11

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (router_irq_cfg == strap_r.gpio[7:6]);
  endproperty
  a_irq: assert property (p_irq) else $error("router interrupt config wrong"); // see RULE12

  property p_route;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (ethernet_debug_link_route == strap_r.gpio[9:8]) &&
                    (ethernet_debug_link_to_dbg == (strap_r.gpio[9:8] == RSCD_ROUTE_DBG));
  endproperty
  a_route: assert property (p_route) else $error("debug link routing wrong"); // see RULE13

  property p_inst;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (router_instance_id == strap_r.gpio[13:12]);
  endproperty
  a_inst: assert property (p_inst) else $error("router instance wrong"); // see RULE15

  property p_edac;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> (prom_edac_en == strap_r.gpio[RSCD_GP_PEDAC]);
  endproperty
  a_edac: assert property (p_edac) else $error("prom correction wrong"); // see RULE16

  property p_pinmux;
    @(posedge pclk) disable iff (!presetn)
      config_valid |-> (pin_function_enable_register == $past(pinfn_r));
  endproperty
  a_pinmux: assert property (p_pinmux) else $error("pin function output wrong"); // see RULE17

  property p_cfg_hold;
    @(posedge pclk) disable iff (!presetn)
      s_settled |-> $stable(clk_cfg) && $stable(cpu0_run) && $stable(prom_width16);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("decoded config changed"); // see RULE20

  property p_refuse;
    @(posedge pclk) disable iff (!presetn)
      (acc && !wr_pinfn && (state_r == RSCD_ST_RUN)) |=> $stable(pinfn_r);
  endproperty
  a_refuse: assert property (p_refuse) else $error("pin function changed"); // see RULE20

  property p_pready;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_pready: assert property (p_pready) else $error("bus ready wrong"); // see RULE18

  property p_slverr;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> (pslverr == !$past(mapped));
  endproperty
  a_slverr: assert property (p_slverr) else $error("bus error flag wrong"); // see RULE18

endmodule : rscd_strap_decoder
`default_nettype wire

/* File: rscd_pkg.sv */
// package for the reset strap configuration decoder
package rscd_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] RSCD_OFS_STRAP  = 12'h000;
  localparam logic [11:0] RSCD_OFS_CLOCK  = 12'h004;
  localparam logic [11:0] RSCD_OFS_SYSCFG = 12'h008;
  localparam logic [11:0] RSCD_OFS_ROUTE  = 12'h00C;
  localparam logic [11:0] RSCD_OFS_PINFN  = 12'h010;

  // ------------------------------------------------------------------
  // widths, fields and reset values
  // ------------------------------------------------------------------
  localparam int          RSCD_GP_W        = 16;
  localparam int          RSCD_PINFN_W     = 22;
  localparam logic [21:0] RSCD_PINFN_PROM  = 22'h3FFFFF;
  localparam logic [21:0] RSCD_PINFN_PERI  = 22'h000000;
  localparam logic [5:0]  RSCD_ETHERNET_DEBUG_LINK_OFF    = 6'h3F;
  localparam logic [1:0]  RSCD_ROUTE_DBG   = 2'h3;
  localparam int          RSCD_GP_PROMW    = 10;
  localparam int          RSCD_GP_PEDAC    = 14;
  localparam int          RSCD_GP_PINMUX   = 15;
  localparam logic [3:0]  RSCD_MUL_SYS     = 4'h5;
  localparam logic [3:0]  RSCD_MUL_MEM     = 4'h2;
  localparam logic [3:0]  RSCD_MUL_SPW     = 4'h8;
  localparam logic [3:0]  RSCD_MUL_ONE     = 4'h1;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] gpio;
    logic [2:0]  pll_bypass;
    logic        mem_clksel;
    logic        break_n;
    logic        dsu_en;
    logic        wdog_en;
    logic        mem_width;
    logic        pci_mode;
    logic        pll_lock_ignore;
  } rscd_strap_type;

  typedef struct packed {
    logic [3:0] sys_mul;
    logic [3:0] mem_mul;
    logic [3:0] spw_mul;
    logic       mem_ext_src;
    logic       spw_pll_en;
    logic       sys_pll_en;
    logic       mem_pll_en;
  } rscd_clk_type;

  typedef enum logic [0:0] {
    RSCD_ST_CAPTURE = 1'b0,
    RSCD_ST_RUN     = 1'b1
  } rscd_state_type;

endpackage : rscd_pkg

/* File: rscd_board_model.sv */
// board strap switches and configuration plug feeding the decoder
`timescale 1ns/100ps
`default_nettype none
module rscd_board_model
  import rscd_pkg::*;
(
  // switch settings and plug choice
  input  wire rscd_strap_type switches,
  input  wire logic [1:0]     plug_sel,
  // strap pins
  output var  rscd_strap_type strap_out
);
  // plug 0 full width, plug 1 half with pci, other plugs half with ethernet
  always_comb begin
    strap_out           = switches;
    strap_out.mem_width = (plug_sel == 2'h0);
    strap_out.pci_mode  = (plug_sel == 2'h1);
  end
endmodule : rscd_board_model
`default_nettype wire

/* File: tb_reset_strap_config_decoder.sv */
// self-checking bench for the reset strap configuration decoder
`timescale 1ns/100ps
`default_nettype none
module tb_reset_strap_config_decoder;
  import rscd_pkg::*;
  // ------------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------------
  logic           pclk = 1'b0, presetn = 1'b0, snap = 1'b0, cv_seen = 1'b0;
  logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]    paddr = 12'h000;
  logic [31:0]    pwdata = 32'h00000000;
  rscd_strap_type sw = '0;
  logic [1:0]     plug_sel = 2'h0;
  rscd_strap_type strap_w;
  wire  [31:0]    prdata;
  wire            pready, pslverr, cpu0_run, dsu_en, wd_en, mem_full, up_pci, up_eth;
  wire            edl_en, edl_dbg, prom16, edac, config_valid;
  wire  [5:0]     edl_addr;
  wire  [1:0]     irq_cfg, edl_route, inst_id;
  wire  [21:0]    pinfn;
  rscd_clk_type   clk_cfg;
  wire  [59:0]    cfg_seen = {clk_cfg, cpu0_run, dsu_en, wd_en, mem_full, up_pci, up_eth,
                              edl_addr, edl_en, irq_cfg, edl_route, edl_dbg, prom16, inst_id,
                              edac, pinfn};
  logic [59:0]    cfg_q[$];
  logic [32:0]    bus_q[$];
  int             err_count = 0, check_count = 0;
  always #10 pclk = ~pclk;
  rscd_board_model board (.switches(sw), .plug_sel(plug_sel), .strap_out(strap_w));
  rscd_strap_decoder dut (
    .pclk(pclk), .presetn(presetn), .strap_in(strap_w), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_cfg(clk_cfg), .cpu0_run(cpu0_run), .debug_support_unit_en(dsu_en),
    .watchdog_reset_enable(wd_en), .memory_width_full(mem_full), .upper_pins_pci(up_pci),
    .upper_pins_eth1(up_eth), .ethernet_debug_link_addr(edl_addr),
    .ethernet_debug_link_en(edl_en), .router_irq_cfg(irq_cfg),
    .ethernet_debug_link_route(edl_route), .ethernet_debug_link_to_dbg(edl_dbg),
    .prom_width16(prom16), .router_instance_id(inst_id), .prom_edac_en(edac),
    .pin_function_enable_register(pinfn), .config_valid(config_valid));
  // ------------------------------------------------------------------
  // expectations, compares and closing
  // ------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [59:0] exp_cfg(input rscd_strap_type s);
    rscd_clk_type c;
    logic         half;
    c.sys_mul     = s.pll_bypass[0] ? 4'h1 : 4'h5;
    c.sys_pll_en  = ~s.pll_bypass[0];
    c.mem_ext_src = s.mem_clksel;
    c.mem_mul     = (s.mem_clksel && !s.pll_bypass[1]) ? 4'h2 : 4'h1;
    c.mem_pll_en  = s.mem_clksel & ~s.pll_bypass[1];
    c.spw_mul     = s.pll_bypass[2] ? 4'h1 : 4'h8;
    c.spw_pll_en  = ~s.pll_bypass[2];
    half          = ~s.mem_width;
    return {c, s.break_n, s.dsu_en, s.wdog_en, s.mem_width,
            half & s.pci_mode, half & ~s.pci_mode,
            s.gpio[5:0], s.gpio[5:0] != 6'h3F, s.gpio[7:6],
            s.gpio[9:8], &s.gpio[9:8], s.gpio[10], s.gpio[13:12],
            s.gpio[14], s.gpio[15] ? 22'h000000 : 22'h3FFFFF};
  endfunction : exp_cfg
  task automatic cmp_cfg(input string nm, input logic [59:0] e, input logic [59:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_cfg
  task automatic cmp_bus(input string nm, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_bus
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // ------------------------------------------------------------------
  // monitor: takes the oldest note whenever a result appears
  // ------------------------------------------------------------------
  always @(posedge pclk) begin
    if (snap && cfg_q.size() > 0) begin
      cmp_cfg("config snapshot", cfg_q.pop_front(), cfg_seen);
      if (!presetn)
        cmp_bus("config valid in reset", 33'h0, {32'h0, config_valid});
    end else if (!presetn) begin
      cv_seen = 1'b0;
    end else if (config_valid === 1'b1 && !cv_seen && cfg_q.size() > 0) begin
      cv_seen = 1'b1;
      cmp_cfg("config after reset", cfg_q.pop_front(), cfg_seen);
    end
    if (psel && penable && pready === 1'b1 && bus_q.size() > 0) begin
      cmp_bus("apb answer", bus_q.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
    end
  end
  // ------------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------------
  task automatic pulse_snap(input logic [59:0] e);
    cfg_q.push_back(e);
    @(posedge pclk) snap <= 1'b1;
    @(posedge pclk) snap <= 1'b0;
  endtask : pulse_snap
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] rd);
    int n;
    bus_q.push_back({err, wr ? 32'h0 : rd});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      close_out();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run_pass(input rscd_strap_type s, input logic [1:0] plug);
    logic [59:0]    e;
    rscd_strap_type cap;
    int             n;
    @(posedge pclk) presetn <= 1'b0;
    sw       <= s;
    plug_sel <= plug;
    pulse_snap({38'h0, 22'h3FFFFF});
    @(posedge pclk) presetn <= 1'b1;
    cap = strap_w;
    e   = exp_cfg(cap);
    cfg_q.push_back(e);
    n = 0;
    while (config_valid !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    if (config_valid !== 1'b1) begin
      err_count++;
      close_out();
    end
    sw       <= ~s;       // later strap changes must be ignored
    plug_sel <= plug + 2'h1;
    apb(1'b1, 12'h000, 32'hFFFFFFFF, 1'b0, 32'h0);
    apb(1'b0, 12'h000, 32'h0, 1'b0, {6'h00, cap});
    apb(1'b0, 12'h004, 32'h0, 1'b0, {16'h0000, e[59:44]});
    apb(1'b0, 12'h008, 32'h0, 1'b0, {26'h0, cap[5:0]});
    apb(1'b0, 12'h00C, 32'h0, 1'b0, {16'h0000, cap.gpio});
    apb(1'b0, 12'h014, 32'h0, 1'b1, 32'h0);
    apb(1'b1, 12'h020, 32'h0, 1'b1, 32'h0);
    pulse_snap(e);
    apb(1'b1, 12'h010, 32'h000FFCFF, 1'b0, 32'h0);
    apb(1'b0, 12'h010, 32'h0, 1'b0, 32'h000FFCFF);
    pulse_snap({e[59:22], 22'h0FFCFF});
  endtask : run_pass
  initial begin
    logic [15:0]    r;
    rscd_strap_type s;
    r = 16'h001E;
    for (int k = 0; k < 8; k++) begin
      r        = lfsr(r);
      s[25:10] = r;
      r        = lfsr(r);
      s[9:0]   = r[9:0];
      if (k == 0)
        s = '1;
      if (k == 1)
        s = '0;
      run_pass(s, r[9:8]);
    end
    repeat (3) @(posedge pclk);
    if (cfg_q.size() != 0 || bus_q.size() != 0)
      err_count++;
    close_out();
  end
endmodule : tb_reset_strap_config_decoder
`default_nettype wire
